// ---- logic/ics_cfg.svh ----
// Purpose: Register indices, field positions, reset values for the input clock selector
// Assumes: Byte address of a register is four times its index
// Notes:   Definitions only
`ifndef ICS_CFG_SVH
`define ICS_CFG_SVH

// Register indices (byte address = index * 4)
`define ICS_IDX_SEL_CTRL     12'h52A
`define ICS_IDX_HOLD_CTRL    12'h52C
`define ICS_IDX_FORCE        12'h535
`define ICS_IDX_SWITCHING    12'h536
`define ICS_IDX_MASKS        12'h537
`define ICS_IDX_RANK01       12'h538
`define ICS_IDX_RANK23       12'h539
`define ICS_IDX_HSW_SETUP    12'h53A
`define ICS_IDX_ZDM_CTRL     12'h541
`define ICS_IDX_DET_CTRL     12'h542
`define ICS_IDX_STATUS       12'h543

// Writable bits of each register
`define ICS_WMASK_SEL_CTRL   8'h06
`define ICS_WMASK_HOLD_CTRL  8'h01
`define ICS_WMASK_FORCE      8'h01
`define ICS_WMASK_SWITCHING  8'h07
`define ICS_WMASK_MASKS      8'hFF
`define ICS_WMASK_RANK       8'h77
`define ICS_WMASK_HSW_SETUP  8'h0F
`define ICS_WMASK_ZDM_CTRL   8'h01
`define ICS_WMASK_DET_CTRL   8'hFF

// Reset values
`define ICS_RST_SEL_CTRL     8'h00
`define ICS_RST_HOLD_CTRL    8'h01
`define ICS_RST_FORCE        8'h00
`define ICS_RST_SWITCHING    8'h00
`define ICS_RST_MASKS        8'h00
`define ICS_RST_RANK01       8'h21
`define ICS_RST_RANK23       8'h43
`define ICS_RST_HSW_SETUP    8'h02
`define ICS_RST_ZDM_CTRL     8'h00
`define ICS_RST_DET_CTRL     8'hFF

// Field positions
`define ICS_POLICY_LSB       0
`define ICS_HITLESS_BIT      2
`define ICS_MANUAL_LSB       1
`define ICS_OOF_MASK_LSB     4
`define ICS_FAST_EN_LSB      4
`define ICS_RANK_HI_LSB      4
`define ICS_STAT_HOLD_BIT    2
`define ICS_STAT_BUILD_BIT   3
`define ICS_STAT_AVAIL_LSB   4

`endif

// ---- logic/ics_pkg.sv ----
// Purpose: Types shared by the input clock selector files
// Assumes: Constants live in ics_cfg.svh
// Notes:   None
`default_nettype none
package ics_pkg;

  typedef enum logic [1:0] {
    ICS_POL_MANUAL,
    ICS_POL_AUTO_NONREV,
    ICS_POL_AUTO_REV,
    ICS_POL_RESERVED
  } ics_policy_t;

  typedef enum logic [1:0] {
    ICS_ST_LOCKED,
    ICS_ST_HOLDOVER,
    ICS_ST_NO_REF
  } ics_sel_state_t;

  typedef struct packed {
    logic [7:0]     sel_ctrl;
    logic [7:0]     hold_ctrl;
    logic [7:0]     force_hold;
    logic [7:0]     switching;
    logic [7:0]     masks;
    logic [7:0]     rank01;
    logic [7:0]     rank23;
    logic [7:0]     hsw_setup;
    logic [7:0]     zdm_ctrl;
    logic [7:0]     det_ctrl;
    logic           wr_pend;
    logic [11:0]    wr_idx;
    logic [31:0]    rdata;
    logic           ready;
    logic [1:0]     active;
    logic           holdover;
    logic           buildout;
    logic           switch_pulse;
    logic           resp;
    ics_sel_state_t st;
  } ics_state_t;

endpackage
`default_nettype wire

// ---- logic/ics_alarm_qualify.sv ----
// Purpose: Applies alarm masks and rank validity to decide which inputs are usable
// Assumes: Alarm inputs are synchronous to core_clk
// Notes:   Purely combinational; the top registers whatever it drives out
`timescale 1ns/1ps
`default_nettype none
module ics_alarm_qualify #(
  parameter int N_IN = 4
) (
  input  wire logic [N_IN-1:0]   signal_absent_alarm,
  input  wire logic [N_IN-1:0]   freq_offset_alarm,
  input  wire logic [N_IN-1:0]   signal_absent_alarm_mask,
  input  wire logic [N_IN-1:0]   freq_offset_alarm_mask,
  input  wire logic [N_IN*3-1:0] ranks,
  output logic      [N_IN-1:0]   alarm_free,
  output logic      [N_IN-1:0]   available
);

  genvar i;
  generate
    for (i = 0; i < N_IN; i++) begin : g_in
      logic [2:0] rk;
      assign rk = ranks[i*3 +: 3];
      // A masked alarm never reaches the selection logic
      assign alarm_free[i] = ~(signal_absent_alarm[i] & ~signal_absent_alarm_mask[i])
                           & ~(freq_offset_alarm[i] & ~freq_offset_alarm_mask[i]);
      // Reserved rank codes are treated like no rank at all
      assign available[i] = alarm_free[i] && rk != 3'h0 && rk <= 3'h4;
    end
  endgenerate

endmodule
`default_nettype wire

// ---- logic/ics_rank_picker.sv ----
// Purpose: Finds the usable input with the numerically lowest rank
// Assumes: Only ranks 1 to 4 are offered as usable
// Notes:   Scanning upward with a strict compare keeps the lower index on ties
`timescale 1ns/1ps
`default_nettype none
module ics_rank_picker #(
  parameter int N_IN = 4
) (
  input  wire logic [N_IN-1:0]   available,
  input  wire logic [N_IN*3-1:0] ranks,
  output logic      [1:0]        best,
  output logic                   any
);

  logic [2:0] best_rank;

  always_comb begin
    best      = 2'h0;
    best_rank = 3'h7;
    any       = 1'b0;
    for (int i = 0; i < N_IN; i++) begin
      if (available[i] && (!any || ranks[i*3 +: 3] < best_rank)) begin
        best      = 2'(i);
        best_rank = ranks[i*3 +: 3];
        any       = 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// ---- logic/ics_selector_top.sv ----
// Purpose: Input reference selection for the loop, with AHB-Lite register access
// Assumes: Alarm and mode inputs are synchronous to core_clk; zero wait-state slave
// Notes:   Registers are byte wide, one per aligned word, upper bits read as zero
//
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "ics_cfg.svh"

// Functional notes
// - Force-holdover bit set puts the loop into holdover whatever the inputs do if holdover-enable is 1, else into the no-reference state.
// - Policy field: 0 manual, 1 auto non-revertive, 2 auto revertive, 3 reserved.
// - Hitless bit 0 gives glitchless changes; 1 gives hitless with phase buildout.
// - No hitless switching while zero delay mode is on.
// - Signal-absent mask bit per input hides that alarm from selection.
// - Frequency-offset mask bit per input hides that alarm from selection.
// - Offset mask reads and acts as 1 when both offset detectors are off.
// - Selection outcome from unmasked alarms can send the loop into holdover.
// - Revertive mode always picks the available input with lowest rank value; non-revertive does so only when leaving its current input.
// - Equal ranks resolve in input order 0, 1, 2, 3.
// - Manual choice field selects input 0 to 3 directly.
// - Holdover is entered only while holdover-enable is 1.
module ics_selector_top
  import ics_pkg::*;
#(
  parameter int N_IN = 4
) (
  input  wire logic            core_clk,
  input  wire logic            reset_n,
  input  wire logic            hsel,
  input  wire logic [31:0]     haddr,
  input  wire logic [1:0]      htrans,
  input  wire logic            hwrite,
  input  wire logic [2:0]      hsize,
  input  wire logic [31:0]     hwdata,
  input  wire logic            hready,
  output logic                 hreadyout,
  output logic [31:0]          hrdata,
  output logic                 hresp,
  input  wire logic [N_IN-1:0] signal_absent_alarm,
  input  wire logic [N_IN-1:0] freq_offset_alarm,
  output logic [1:0]           active_input,
  output logic                 holdover_active,
  output logic                 phase_buildout_on,
  output logic                 input_switched
);

  ics_state_t q;
  ics_state_t d;

  logic [N_IN-1:0]   absent_mask;
  logic [N_IN-1:0]   offset_mask;
  logic [N_IN-1:0]   alarm_free;
  logic [N_IN-1:0]   available;
  logic [N_IN*3-1:0] ranks;
  logic [1:0]        best;
  logic              any_avail;
  ics_policy_t       policy;
  logic [1:0]        manual_choice;
  logic              hold_allowed;
  logic              zero_delay_enable;
  logic              hitless_enable;
  logic [7:0]        status;
  logic              addr_ok;
  logic [11:0]       addr_idx;

  // One decode serves both the read and the write path
  function automatic logic reg_hit(input logic [11:0] idx, input logic [11:0] want);
    reg_hit = (idx == want);
  endfunction

  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wd,
                                       input logic [7:0] wmask);
    merge = (old & ~wmask) | (wd & wmask);
  endfunction

  // Offset mask forced high while both detectors of an input are off
  assign absent_mask       = q.masks[3:0];
  assign offset_mask       = q.masks[`ICS_OOF_MASK_LSB +: 4]
                           | ~(q.det_ctrl[3:0] | q.det_ctrl[`ICS_FAST_EN_LSB +: 4]);
  assign ranks             = {q.rank23[`ICS_RANK_HI_LSB +: 3], q.rank23[2:0],
                              q.rank01[`ICS_RANK_HI_LSB +: 3], q.rank01[2:0]};
  assign policy            = ics_policy_t'(q.switching[`ICS_POLICY_LSB +: 2]);
  assign hitless_enable    = q.switching[`ICS_HITLESS_BIT];
  assign manual_choice     = q.sel_ctrl[`ICS_MANUAL_LSB +: 2];
  assign hold_allowed      = q.hold_ctrl[0];
  assign zero_delay_enable = q.zdm_ctrl[0];
  assign addr_idx          = haddr[13:2];
  assign addr_ok           = haddr[31:14] == 18'h0 && haddr[1:0] == 2'h0;

  ics_alarm_qualify #(
    .N_IN(N_IN)
  ) u_qualify (
    .signal_absent_alarm     (signal_absent_alarm),
    .freq_offset_alarm       (freq_offset_alarm),
    .signal_absent_alarm_mask(absent_mask),
    .freq_offset_alarm_mask  (offset_mask),
    .ranks                   (ranks),
    .alarm_free              (alarm_free),
    .available               (available)
  );

  ics_rank_picker #(
    .N_IN(N_IN)
  ) u_picker (
    .available(available),
    .ranks    (ranks),
    .best     (best),
    .any      (any_avail)
  );

  assign status = {available, q.buildout, q.holdover, q.active};

  always_comb begin
    logic [1:0] want;
    logic       ref_ok;
    logic       go_hold;
    logic [7:0] wd;
    logic [7:0] rd;
    want    = q.active;
    ref_ok  = 1'b0;
    go_hold = 1'b0;
    wd      = hwdata[7:0];
    rd      = 8'h00;
    d       = q;

    d.ready        = 1'b1;
    d.switch_pulse = 1'b0;
    // Every transfer is answered OKAY
    d.resp         = 1'b0;

    // Data phase of a pending write lands here
    if (q.wr_pend) begin
      d.wr_pend = 1'b0;
      if (reg_hit(q.wr_idx, `ICS_IDX_SEL_CTRL)) begin
        d.sel_ctrl = merge(q.sel_ctrl, wd, `ICS_WMASK_SEL_CTRL);
      end else if (reg_hit(q.wr_idx, `ICS_IDX_HOLD_CTRL)) begin
        d.hold_ctrl = merge(q.hold_ctrl, wd, `ICS_WMASK_HOLD_CTRL);
      end else if (reg_hit(q.wr_idx, `ICS_IDX_FORCE)) begin
        d.force_hold = merge(q.force_hold, wd, `ICS_WMASK_FORCE);
      end else if (reg_hit(q.wr_idx, `ICS_IDX_SWITCHING)) begin
        d.switching = merge(q.switching, wd, `ICS_WMASK_SWITCHING);
      end else if (reg_hit(q.wr_idx, `ICS_IDX_MASKS)) begin
        d.masks = merge(q.masks, wd, `ICS_WMASK_MASKS);
      end else if (reg_hit(q.wr_idx, `ICS_IDX_RANK01)) begin
        d.rank01 = merge(q.rank01, wd, `ICS_WMASK_RANK);
      end else if (reg_hit(q.wr_idx, `ICS_IDX_RANK23)) begin
        d.rank23 = merge(q.rank23, wd, `ICS_WMASK_RANK);
      end else if (reg_hit(q.wr_idx, `ICS_IDX_HSW_SETUP)) begin
        // Stored as written; only the default values are meaningful
        d.hsw_setup = merge(q.hsw_setup, wd, `ICS_WMASK_HSW_SETUP);
      end else if (reg_hit(q.wr_idx, `ICS_IDX_ZDM_CTRL)) begin
        d.zdm_ctrl = merge(q.zdm_ctrl, wd, `ICS_WMASK_ZDM_CTRL);
      end else if (reg_hit(q.wr_idx, `ICS_IDX_DET_CTRL)) begin
        d.det_ctrl = merge(q.det_ctrl, wd, `ICS_WMASK_DET_CTRL);
      end
    end

    // Address phase: reads answered in the next cycle, unmapped words read zero
    if (hsel && hready && htrans[1]) begin
      if (hwrite) begin
        d.wr_pend = addr_ok;
        d.wr_idx  = addr_idx;
      end else begin
        if (!addr_ok) begin
          rd = 8'h00;
        end else if (reg_hit(addr_idx, `ICS_IDX_SEL_CTRL)) begin
          rd = q.sel_ctrl;
        end else if (reg_hit(addr_idx, `ICS_IDX_HOLD_CTRL)) begin
          rd = q.hold_ctrl;
        end else if (reg_hit(addr_idx, `ICS_IDX_FORCE)) begin
          rd = q.force_hold;
        end else if (reg_hit(addr_idx, `ICS_IDX_SWITCHING)) begin
          rd = q.switching;
        end else if (reg_hit(addr_idx, `ICS_IDX_MASKS)) begin
          rd = {offset_mask, absent_mask};
        end else if (reg_hit(addr_idx, `ICS_IDX_RANK01)) begin
          rd = q.rank01;
        end else if (reg_hit(addr_idx, `ICS_IDX_RANK23)) begin
          rd = q.rank23;
        end else if (reg_hit(addr_idx, `ICS_IDX_HSW_SETUP)) begin
          rd = q.hsw_setup;
        end else if (reg_hit(addr_idx, `ICS_IDX_ZDM_CTRL)) begin
          rd = q.zdm_ctrl;
        end else if (reg_hit(addr_idx, `ICS_IDX_DET_CTRL)) begin
          rd = q.det_ctrl;
        end else if (reg_hit(addr_idx, `ICS_IDX_STATUS)) begin
          rd = status;
        end
        d.rdata = {24'h000000, rd};
      end
    end

    // Choose the reference the loop should follow
    case (policy)
      ICS_POL_AUTO_NONREV: begin
        // Stay put while locked and the current input is still usable
        if (available[q.active] && q.st == ICS_ST_LOCKED) begin
          want = q.active;
        end else begin
          want = best;
        end
        ref_ok = any_avail;
      end
      ICS_POL_AUTO_REV: begin
        want   = best;
        ref_ok = any_avail;
      end
      default: begin
        // Reserved policy code behaves as manual
        want   = manual_choice;
        ref_ok = alarm_free[manual_choice];
      end
    endcase

    // A lost reference or a forced request leads to holdover when allowed
    go_hold = q.force_hold[0] || !ref_ok;

    case (q.st)
      ICS_ST_LOCKED: begin
        if (go_hold && hold_allowed) begin
          d.st = ICS_ST_HOLDOVER;
        end else if (go_hold) begin
          d.st = ICS_ST_NO_REF;
        end else if (want != q.active) begin
          d.active       = want;
          d.switch_pulse = 1'b1;
        end
      end
      ICS_ST_HOLDOVER: begin
        if (!hold_allowed) begin
          d.st = go_hold ? ICS_ST_NO_REF : ICS_ST_LOCKED;
        end else if (!go_hold) begin
          d.st = ICS_ST_LOCKED;
        end
        if (!go_hold && want != q.active) begin
          d.active       = want;
          d.switch_pulse = 1'b1;
        end
      end
      default: begin
        // Reference gone with holdover disabled: wait for a usable input
        if (go_hold && hold_allowed) begin
          d.st = ICS_ST_HOLDOVER;
        end else if (!go_hold) begin
          d.st = ICS_ST_LOCKED;
          if (want != q.active) begin
            d.active       = want;
            d.switch_pulse = 1'b1;
          end
        end
      end
    endcase

    d.holdover = d.st == ICS_ST_HOLDOVER;
    d.buildout = hitless_enable && !zero_delay_enable;
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      q.sel_ctrl     <= `ICS_RST_SEL_CTRL;
      q.hold_ctrl    <= `ICS_RST_HOLD_CTRL;
      q.force_hold   <= `ICS_RST_FORCE;
      q.switching    <= `ICS_RST_SWITCHING;
      q.masks        <= `ICS_RST_MASKS;
      q.rank01       <= `ICS_RST_RANK01;
      q.rank23       <= `ICS_RST_RANK23;
      q.hsw_setup    <= `ICS_RST_HSW_SETUP;
      q.zdm_ctrl     <= `ICS_RST_ZDM_CTRL;
      q.det_ctrl     <= `ICS_RST_DET_CTRL;
      q.wr_pend      <= 1'b0;
      q.wr_idx       <= 12'h000;
      q.rdata        <= 32'h00000000;
      q.ready        <= 1'b1;
      q.active       <= 2'h0;
      q.holdover     <= 1'b0;
      q.buildout     <= 1'b0;
      q.switch_pulse <= 1'b0;
      q.resp         <= 1'b0;
      q.st           <= ICS_ST_LOCKED;
    end else begin
      q <= d;
    end
  end

  assign hreadyout         = q.ready;
  assign hrdata            = q.rdata;
  assign hresp             = q.resp;
  assign active_input      = q.active;
  assign holdover_active   = q.holdover;
  assign phase_buildout_on = q.buildout;
  assign input_switched    = q.switch_pulse;

endmodule
`default_nettype wire

// ---- verif/ics_selector_properties.sv ----
// Purpose: Port-level properties of the input clock selector
// Assumes: Register shadows are rebuilt from observed bus writes
// Notes:   Bound from the bench top file
`timescale 1ns/1ps
`default_nettype none
`include "ics_cfg.svh"
module ics_selector_properties #(
  parameter int N_IN = 4
) (
  input wire logic            core_clk,
  input wire logic            reset_n,
  input wire logic            hsel,
  input wire logic [31:0]     haddr,
  input wire logic [1:0]      htrans,
  input wire logic            hwrite,
  input wire logic [2:0]      hsize,
  input wire logic [31:0]     hwdata,
  input wire logic            hready,
  input wire logic            hreadyout,
  input wire logic [31:0]     hrdata,
  input wire logic            hresp,
  input wire logic [N_IN-1:0] signal_absent_alarm,
  input wire logic [N_IN-1:0] freq_offset_alarm,
  input wire logic [1:0]      active_input,
  input wire logic            holdover_active,
  input wire logic            phase_buildout_on,
  input wire logic            input_switched
);
  logic        pend_q;
  logic [11:0] idx_q;
  logic [7:0]  frc_q, hen_q, sw_q, msk_q, sel_q, zdm_q;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  // Shadows land on the same edge as the design's own registers
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pend_q <= 1'b0;
      idx_q  <= 12'h000;
      {frc_q, hen_q, sw_q, msk_q, sel_q, zdm_q} <= {8'h00, 8'h01, 32'h0};
    end else begin
      pend_q <= hsel && hready && htrans[1] && hwrite && haddr[31:14] == 18'h0
                && haddr[1:0] == 2'h0;
      idx_q  <= haddr[13:2];
      if (pend_q) begin
        case (idx_q)
          `ICS_IDX_FORCE:     frc_q <= hwdata[7:0];
          `ICS_IDX_HOLD_CTRL: hen_q <= hwdata[7:0];
          `ICS_IDX_SWITCHING: sw_q <= hwdata[7:0];
          `ICS_IDX_MASKS:     msk_q <= hwdata[7:0];
          `ICS_IDX_SEL_CTRL:  sel_q <= hwdata[7:0];
          `ICS_IDX_ZDM_CTRL:  zdm_q <= hwdata[7:0];
          default: ;
        endcase
      end
    end
  end

  sequence s_manual_calm;
    (sw_q[1:0] == 2'h0 || sw_q[1:0] == 2'h3) && !frc_q[0]
      && signal_absent_alarm == '0 && freq_offset_alarm == '0;
  endsequence

  a_force_hold: assert property (frc_q[0] && hen_q[0] |=> holdover_active)
    else $error("force bit set but no holdover");
  a_hold_off: assert property (!hen_q[0] |=> !holdover_active)
    else $error("holdover while disabled");
  a_zdm_block: assert property (zdm_q[0] |=> !phase_buildout_on)
    else $error("buildout in zero delay mode");
  a_buildout_on: assert property (sw_q[2] && !zdm_q[0] |=> phase_buildout_on)
    else $error("hitless set but buildout off");
  a_glitchless_mode: assert property (!sw_q[2] |=> !phase_buildout_on)
    else $error("buildout without hitless");
  a_manual_pick: assert property (s_manual_calm |=>
    active_input == $past(sel_q[2:1]) && !holdover_active)
    else $error("manual choice not followed");
  a_auto_hold: assert property ((sw_q[1:0] == 2'h1 || sw_q[1:0] == 2'h2) && hen_q[0]
    && (&signal_absent_alarm) && msk_q[3:0] == 4'h0 |=> holdover_active)
    else $error("no holdover with all inputs lost");
  a_switch_pulse: assert property (input_switched == (active_input != $past(active_input)))
    else $error("switch pulse does not match input change");
  a_resp_okay: assert property (!hresp)
    else $error("error response seen");
endmodule
`default_nettype wire

// ---- verif/ics_ref_sources.sv ----
// Purpose: Model of the four reference sources and their alarm detectors
// Assumes: Alarms are synchronous to core_clk
// Notes:   Lag of zero answers promptly; larger lag mimics slow detectors
`timescale 1ns/1ps
`default_nettype none
module ics_ref_sources (
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  input  wire logic [3:0] los_want,
  input  wire logic [3:0] oof_want,
  input  wire logic [3:0] lag,
  output logic      [3:0] signal_absent_alarm,
  output logic      [3:0] freq_offset_alarm
);
  logic [3:0] wait_q;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      {signal_absent_alarm, freq_offset_alarm, wait_q} <= 12'h000;
    end else if ({los_want, oof_want} == {signal_absent_alarm, freq_offset_alarm}) begin
      wait_q <= 4'h0;
    end else if (wait_q >= lag) begin
      {signal_absent_alarm, freq_offset_alarm} <= {los_want, oof_want};
      wait_q <= 4'h0;
    end else begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule
`default_nettype wire

// ---- verif/ics_selector_bench.sv ----
// Purpose: Self-checking bench for the input clock selector
// Assumes: Zero wait-state slave; outputs follow inputs one edge later
// Notes:   Hitless setup register is only read, never written
`timescale 1ns/1ps
`default_nettype none
`include "ics_cfg.svh"
module ics_selector_bench;
  localparam logic [11:0] IX [8] = '{`ICS_IDX_FORCE, `ICS_IDX_SWITCHING, `ICS_IDX_MASKS,
    `ICS_IDX_RANK01, `ICS_IDX_RANK23, `ICS_IDX_SEL_CTRL, `ICS_IDX_HOLD_CTRL, `ICS_IDX_HSW_SETUP};
  localparam logic [7:0] RV [8] = '{`ICS_RST_FORCE, `ICS_RST_SWITCHING, `ICS_RST_MASKS,
    `ICS_RST_RANK01, `ICS_RST_RANK23, `ICS_RST_SEL_CTRL, `ICS_RST_HOLD_CTRL, `ICS_RST_HSW_SETUP};
  localparam logic [7:0] WM [7] = '{`ICS_WMASK_FORCE, `ICS_WMASK_SWITCHING, `ICS_WMASK_MASKS,
    `ICS_WMASK_RANK, `ICS_WMASK_RANK, `ICS_WMASK_SEL_CTRL, `ICS_WMASK_HOLD_CTRL};
  logic        core_clk = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0]  htrans = 2'h0, active_input;
  logic [2:0]  hsize = 3'h2;
  logic [3:0]  los_want = 4'h0, oof_want = 4'h0, lag = 4'h0;
  logic [3:0]  signal_absent_alarm, freq_offset_alarm;
  logic        hreadyout, hresp, holdover_active, phase_buildout_on, input_switched;
  wire         hready;
  int          fail_count = 0, checks = 0, pulses = 0;

  always #5 core_clk = ~core_clk;
  assign hready = hreadyout;
  // Counted off the sampling edge so tasks never race the counter
  always @(negedge core_clk) if (input_switched === 1'b1) pulses++;

  ics_selector_top dut (.core_clk(core_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .signal_absent_alarm(signal_absent_alarm), .freq_offset_alarm(freq_offset_alarm),
    .active_input(active_input), .holdover_active(holdover_active),
    .phase_buildout_on(phase_buildout_on), .input_switched(input_switched));
  ics_ref_sources src (.core_clk(core_clk), .reset_n(reset_n), .los_want(los_want),
    .oof_want(oof_want), .lag(lag), .signal_absent_alarm(signal_absent_alarm),
    .freq_offset_alarm(freq_offset_alarm));

  task final_report;
    if (fail_count == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  function logic [31:0] st();
    return {28'h0, phase_buildout_on, holdover_active, active_input};
  endfunction

  task xfer(input logic w, input logic [11:0] i, input logic [7:0] d, output logic [31:0] r);
    hsel   <= 1'b1;
    haddr  <= {18'h0, i, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge core_clk);
    while (hready !== 1'b1) @(posedge core_clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    @(posedge core_clk);
    while (hready !== 1'b1) @(posedge core_clk);
    r = hrdata;
  endtask

  task wr(input logic [11:0] i, input logic [7:0] d);
    logic [31:0] r;
    xfer(1'b1, i, d, r);
    repeat (2) @(posedge core_clk);
  endtask

  task rchk(input logic [11:0] i, input logic [31:0] e);
    logic [31:0] r;
    xfer(1'b0, i, 8'h00, r);
    chk(r, e);
  endtask

  task al(input logic [3:0] l, input logic [3:0] o);
    los_want <= l;
    oof_want <= o;
    for (int k = 0; k < 60 && {signal_absent_alarm, freq_offset_alarm} !== {l, o}; k++)
      @(posedge core_clk);
    repeat (3) @(posedge core_clk);
  endtask

  task t_regs;
    logic [7:0] pat;
    chk(st(), 32'h0);
    for (int k = 0; k < 8; k++) begin
      rchk(IX[k], {24'h0, RV[k]});
      if (k < 7) begin
        // Rank codes 5 to 7 are off limits, so rank words get a legal pattern
        pat = (k == 3 || k == 4) ? 8'hCC : 8'hFF;
        wr(IX[k], pat);
        rchk(IX[k], {24'h0, pat & WM[k]});
        wr(IX[k], RV[k]);
      end
    end
    wr(12'h540, 8'hFF);
    rchk(12'h540, 32'h0);
  endtask

  task t_manual;
    int n0;
    n0 = pulses;
    for (int c = 0; c < 4; c++) begin
      wr(`ICS_IDX_SEL_CTRL, {5'h0, 2'(c), 1'b0});
      for (int p = 0; p < 4; p += 3) begin
        wr(`ICS_IDX_SWITCHING, {6'h0, 2'(p)});
        chk(st(), 32'(c));
      end
    end
    chk(32'(pulses - n0), 32'h3);
    wr(`ICS_IDX_SWITCHING, 8'h00);
    al(4'h8, 4'h0);
    chk(st(), 32'h7);
    wr(`ICS_IDX_MASKS, 8'h08);
    chk(st(), 32'h3);
    al(4'h8, 4'h8);
    chk(st(), 32'h7);
    wr(`ICS_IDX_MASKS, 8'h88);
    chk(st(), 32'h3);
    wr(`ICS_IDX_MASKS, 8'h00);
    wr(`ICS_IDX_SEL_CTRL, 8'h00);
    wr(`ICS_IDX_DET_CTRL, 8'hEE);
    rchk(`ICS_IDX_MASKS, 32'h10);
    al(4'h0, 4'h1);
    chk(st(), 32'h0);
    wr(`ICS_IDX_DET_CTRL, 8'hFF);
    chk(st(), 32'h4);
    al(4'h0, 4'h0);
  endtask

  task t_auto;
    lag <= 4'h5;
    wr(`ICS_IDX_SWITCHING, 8'h02);
    chk(st(), 32'h0);
    al(4'h1, 4'h0);
    chk(st(), 32'h1);
    al(4'h0, 4'h0);
    chk(st(), 32'h0);
    wr(`ICS_IDX_SWITCHING, 8'h01);
    al(4'h1, 4'h0);
    al(4'h0, 4'h0);
    chk(st(), 32'h1);
    al(4'h2, 4'h0);
    chk(st(), 32'h0);
    al(4'h0, 4'h0);
    wr(`ICS_IDX_RANK01, 8'h11);
    wr(`ICS_IDX_RANK23, 8'h11);
    wr(`ICS_IDX_SWITCHING, 8'h02);
    al(4'h1, 4'h0);
    chk(st(), 32'h1);
    al(4'h3, 4'h0);
    chk(st(), 32'h2);
    al(4'h0, 4'h0);
    wr(`ICS_IDX_RANK01, 8'h00);
    wr(`ICS_IDX_RANK23, 8'h32);
    chk(st(), 32'h2);
    wr(`ICS_IDX_RANK23, 8'h23);
    chk(st(), 32'h3);
    wr(`ICS_IDX_RANK23, 8'h03);
    chk(st(), 32'h2);
    wr(`ICS_IDX_RANK01, 8'h21);
    wr(`ICS_IDX_RANK23, 8'h43);
    chk(st(), 32'h0);
    lag <= 4'h0;
  endtask

  task t_hold;
    al(4'hF, 4'h0);
    chk(st(), 32'h4);
    wr(`ICS_IDX_HOLD_CTRL, 8'h00);
    chk(st(), 32'h0);
    wr(`ICS_IDX_HOLD_CTRL, 8'h01);
    al(4'h0, 4'h0);
    wr(`ICS_IDX_FORCE, 8'h01);
    chk(st(), 32'h4);
    wr(`ICS_IDX_HOLD_CTRL, 8'h00);
    chk(st(), 32'h0);
    wr(`ICS_IDX_HOLD_CTRL, 8'h01);
    wr(`ICS_IDX_FORCE, 8'h00);
    chk(st(), 32'h0);
  endtask

  task t_hit;
    wr(`ICS_IDX_SWITCHING, 8'h06);
    chk(st(), 32'h8);
    wr(`ICS_IDX_ZDM_CTRL, 8'h01);
    chk(st(), 32'h0);
    wr(`ICS_IDX_ZDM_CTRL, 8'h00);
    chk(st(), 32'h8);
    wr(`ICS_IDX_SWITCHING, 8'h02);
    chk(st(), 32'h0);
  endtask

  initial begin
    repeat (12) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    t_regs;
    t_manual;
    t_auto;
    t_hold;
    t_hit;
    final_report;
  end

  // The whole sequence needs well under a tenth of this span
  initial begin
    repeat (30000) @(posedge core_clk);
    fail_count++;
    final_report;
  end
endmodule

bind ics_selector_top ics_selector_properties #(.N_IN(N_IN)) u_props (.core_clk(core_clk),
  .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
  .hresp(hresp), .signal_absent_alarm(signal_absent_alarm),
  .freq_offset_alarm(freq_offset_alarm), .active_input(active_input),
  .holdover_active(holdover_active), .phase_buildout_on(phase_buildout_on),
  .input_switched(input_switched));
`default_nettype wire
